// [design/faps_pkg.sv]
package faps_pkg;

  // ==========================================================
  // status byte selection and program/erase kinds
  typedef enum logic [1:0] {
    SEL_LOW  = 2'h0,
    SEL_MID  = 2'h1,
    SEL_HIGH = 2'h2
  } faps_sel_t;

  typedef enum logic [2:0] {
    OP_PROG  = 3'h0,
    OP_SECT  = 3'h1,
    OP_BLK32 = 3'h2,
    OP_BLK64 = 3'h3,
    OP_CHIP  = 3'h4
  } faps_op_t;

  // ==========================================================
  // bit positions inside each status byte
  localparam int LOW_SRP_BIT = 7;
  localparam int LOW_BP_MSB = 6;
  localparam int LOW_BP_LSB = 2;
  localparam int LOW_LATCH_BIT = 1;
  localparam int LOW_BUSY_BIT = 0;
  localparam int MID_ESUS_BIT = 7;
  localparam int MID_COMPL_BIT = 6;
  localparam int MID_LOCK_MSB = 5;
  localparam int MID_LOCK_LSB = 3;
  localparam int MID_PSUS_BIT = 2;
  localparam int MID_QUAD_BIT = 1;
  localparam int MID_SRP_BIT = 0;
  localparam int HIGH_HRST_BIT = 7;
  localparam int HIGH_DRV_MSB = 6;
  localparam int HIGH_DRV_LSB = 5;
  localparam int HIGH_DUMMY_BIT = 0;

  // ==========================================================
  // reset image of the stored bits
  localparam logic [4:0] BP_RST = 5'h00;
  localparam logic [2:0] LOCK_RST = 3'h0;
  localparam logic [1:0] DRV_RST = 2'h1;
  localparam logic BIT_RST = 1'b0;

  // ==========================================================
  // array geometry and decoder constants
  localparam logic [23:0] ADDR_ZERO = 24'h000000;
  localparam logic [23:0] ADDR_TOP = 24'hffffff;
  localparam logic [23:0] ADDR_ONE = 24'h000001;
  localparam logic [24:0] MASK_ONE = 25'h0000001;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_ALL = 3'h7;
  localparam logic [2:0] SMALL_CAP = 3'h4;
  localparam logic [4:0] SMALL_BASE = 5'h0b;
  localparam logic [4:0] LARGE_BASE = 5'h11;
  localparam logic [23:0] PAGE_MASK = 24'h0000ff;
  localparam logic [23:0] SECT_MASK = 24'h000fff;
  localparam logic [23:0] BLK32_MASK = 24'h007fff;
  localparam logic [23:0] BLK64_MASK = 24'h00ffff;

  function automatic logic [23:0] faps_unit_mask(input logic [2:0] kind);
    case (kind)
      OP_PROG: faps_unit_mask = PAGE_MASK;
      OP_SECT: faps_unit_mask = SECT_MASK;
      OP_BLK32: faps_unit_mask = BLK32_MASK;
      OP_BLK64: faps_unit_mask = BLK64_MASK;
      default: faps_unit_mask = ADDR_TOP;
    endcase
  endfunction

  function automatic logic faps_overlap(input logic [23:0] ua, input logic [23:0] ub,
                                        input logic [23:0] lo, input logic [23:0] hi);
    faps_overlap = (ua <= hi) && (ub >= lo);
  endfunction

endpackage

// [design/faps_prot_if.sv]
`timescale 1ns/10ps
interface faps_prot_if;
  logic [4:0] bp;
  logic compl;
  logic [23:0] lo;
  logic [23:0] hi;
  logic none;

  modport dec (input bp, input compl, output lo, output hi, output none);
  modport user (output bp, output compl, input lo, input hi, input none);
endinterface

// [design/faps_decode.sv]
`timescale 1ns/10ps
module faps_decode (
  // protect bits in, range out
  faps_prot_if.dec p
);

  // ==========================================================
  // size of the anchored region
  wire [2:0] code = p.bp[2:0];
  wire [2:0] code_cap = (code > faps_pkg::SMALL_CAP) ? faps_pkg::SMALL_CAP : code;
  wire [4:0] small_log2 = 5'(faps_pkg::SMALL_BASE + {2'h0, code_cap});
  wire [4:0] large_log2 = 5'(faps_pkg::LARGE_BASE + {2'h0, code});
  wire [4:0] size_log2 = p.bp[4] ? small_log2 : large_log2;
  wire [23:0] mask = 24'((faps_pkg::MASK_ONE << size_log2) - faps_pkg::MASK_ONE);

  // ==========================================================
  // complement swaps the anchor end; purely combinational
  wire none_code = (code == faps_pkg::CODE_NONE);
  wire all_code = (code == faps_pkg::CODE_ALL);
  wire is_full = p.compl ? none_code : all_code;
  wire keep_bottom = p.compl ? ~p.bp[3] : p.bp[3];
  wire [23:0] bot_hi = p.compl ? 24'(~mask - faps_pkg::ADDR_ONE) : mask;
  wire [23:0] top_lo = p.compl ? 24'(mask + faps_pkg::ADDR_ONE) : ~mask;

  assign p.none = p.compl ? all_code : none_code;
  assign p.lo = (is_full || p.none || keep_bottom) ? faps_pkg::ADDR_ZERO : top_lo;
  assign p.hi = p.none ? faps_pkg::ADDR_ZERO :
                (is_full || !keep_bottom) ? faps_pkg::ADDR_TOP : bot_hi;

endmodule // faps_decode

// [design/faps_top.sv]
`timescale 1ns/10ps
// Overview of operation
// - low byte: status_protect_lsb, block protect 4..0, write enable latch, in progress
// - mid byte: erase suspend, complement, locks 3..1, program suspend, quad, protect msb
// - security lock bits only set, never return to zero by a write
// - high byte: hold/reset select, drive strength, four reserved bits, dummy select
// - drive strength is one two-bit field at positions 22..21
// - complement inverts the range; code 000 all or none, 111 none or all
// - complement, upper bits 00: protect bottom up to just below top fraction
// - complement, upper bits 01: protect from fraction start up to array top
// - complement, upper bits 10: protect bottom up to just below top 4..32 KB
// - complement, upper bits 11: protect from 4..32 KB up to array top
// - no complement, upper bits 11: codes 011 16 KB, 10X/110 32 KB bottom
// - no complement, upper bits 00: top 1/64 up to 1/2 of array
// - reject program and sector or block erase touching protected region
// - chip erase only with codes 000 plain or 111 complemented
module faps_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // status write command
  input wire logic wr_en_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [7:0] wr_data_i,
  // status read command
  input wire logic rd_en_i,
  input wire logic [1:0] rd_sel_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // volatile state from the sequencer
  input wire logic busy_i,
  input wire logic wr_latch_i,
  input wire logic erase_susp_i,
  input wire logic prog_susp_i,
  // program/erase protection check
  input wire logic op_en_i,
  input wire logic [2:0] op_kind_i,
  input wire logic [23:0] op_addr_i,
  output logic op_done_o,
  output logic op_allow_o,
  output logic op_reject_o,
  // decoded protected range
  output logic prot_none_o,
  output logic [23:0] prot_lo_o,
  output logic [23:0] prot_hi_o,
  // configuration to the rest of the device
  output logic [1:0] status_protect_o,
  output logic [2:0] security_lock_o,
  output logic quad_enable_o,
  output logic [1:0] drive_strength_o,
  output logic dummy_cycle_sel_o,
  output logic hold_reset_sel_o
);

  // ==========================================================
  // stored status bits
  logic srp_lsb_q;
  logic srp_msb_q;
  logic [4:0] bp_q;
  logic compl_q;
  logic [2:0] lock_q;
  logic quad_q;
  logic hrst_q;
  logic [1:0] drv_q;
  logic dummy_q;

  wire wr_low = wr_en_i && (wr_sel_i == faps_pkg::SEL_LOW);
  wire wr_mid = wr_en_i && (wr_sel_i == faps_pkg::SEL_MID);
  wire wr_high = wr_en_i && (wr_sel_i == faps_pkg::SEL_HIGH);

  // volatile bits in the written bytes are dropped here
  wire [4:0] wr_bp = wr_data_i[faps_pkg::LOW_BP_MSB:faps_pkg::LOW_BP_LSB];
  wire [2:0] wr_lock = wr_data_i[faps_pkg::MID_LOCK_MSB:faps_pkg::MID_LOCK_LSB];
  wire [2:0] lock_d = lock_q | wr_lock;
  wire [1:0] wr_drv = wr_data_i[faps_pkg::HIGH_DRV_MSB:faps_pkg::HIGH_DRV_LSB];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      srp_lsb_q <= faps_pkg::BIT_RST;
      bp_q <= faps_pkg::BP_RST;
    end
    else if (wr_low)
    begin
      srp_lsb_q <= wr_data_i[faps_pkg::LOW_SRP_BIT];
      bp_q <= wr_bp;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      compl_q <= faps_pkg::BIT_RST;
      lock_q <= faps_pkg::LOCK_RST;
      quad_q <= faps_pkg::BIT_RST;
      srp_msb_q <= faps_pkg::BIT_RST;
    end
    else if (wr_mid)
    begin
      compl_q <= wr_data_i[faps_pkg::MID_COMPL_BIT];
      lock_q <= lock_d;
      quad_q <= wr_data_i[faps_pkg::MID_QUAD_BIT];
      srp_msb_q <= wr_data_i[faps_pkg::MID_SRP_BIT];
    end
  end

  // reserved high bits are not stored at all, so they read as zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hrst_q <= faps_pkg::BIT_RST;
      drv_q <= faps_pkg::DRV_RST;
      dummy_q <= faps_pkg::BIT_RST;
    end
    else if (wr_high)
    begin
      hrst_q <= wr_data_i[faps_pkg::HIGH_HRST_BIT];
      drv_q <= wr_drv;
      dummy_q <= wr_data_i[faps_pkg::HIGH_DUMMY_BIT];
    end
  end

  // ==========================================================
  // read data assembly
  wire [7:0] low_byte = {srp_lsb_q, bp_q, wr_latch_i, busy_i};
  wire [7:0] mid_byte = {erase_susp_i, compl_q, lock_q, prog_susp_i, quad_q, srp_msb_q};
  wire [7:0] high_byte = {hrst_q, drv_q, 4'h0, dummy_q};
  wire [7:0] rd_mux = (rd_sel_i == faps_pkg::SEL_LOW) ? low_byte :
                      (rd_sel_i == faps_pkg::SEL_MID) ? mid_byte :
                      (rd_sel_i == faps_pkg::SEL_HIGH) ? high_byte : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      rd_data_o <= rd_en_i ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // protection decoder
  faps_prot_if pif ();

  assign pif.bp = bp_q;
  assign pif.compl = compl_q;

  faps_decode u_decode (
    .p(pif.dec)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prot_none_o <= 1'b1;
      prot_lo_o <= faps_pkg::ADDR_ZERO;
      prot_hi_o <= faps_pkg::ADDR_ZERO;
    end
    else
    begin
      prot_none_o <= pif.none;
      prot_lo_o <= pif.lo;
      prot_hi_o <= pif.hi;
    end
  end

  // ==========================================================
  // program/erase check; the whole erase unit is compared, not just its first byte
  wire [23:0] unit_mask = faps_pkg::faps_unit_mask(op_kind_i);
  wire [23:0] unit_lo = op_addr_i & ~unit_mask;
  wire [23:0] unit_hi = op_addr_i | unit_mask;
  wire is_chip = (op_kind_i == faps_pkg::OP_CHIP);
  wire kind_ok = (op_kind_i <= faps_pkg::OP_CHIP);
  wire hits = !pif.none && faps_pkg::faps_overlap(unit_lo, unit_hi, pif.lo, pif.hi);
  wire chip_ok = compl_q ? (bp_q[2:0] == faps_pkg::CODE_ALL) :
                         (bp_q[2:0] == faps_pkg::CODE_NONE);
  wire op_ok = kind_ok && (is_chip ? chip_ok : !hits);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      op_done_o <= 1'b0;
      op_allow_o <= 1'b0;
      op_reject_o <= 1'b0;
    end
    else
    begin
      op_done_o <= op_en_i;
      op_allow_o <= op_en_i && op_ok;
      op_reject_o <= op_en_i && !op_ok;
    end
  end

  // ==========================================================
  // configuration outputs
  assign status_protect_o = {srp_msb_q, srp_lsb_q};
  assign security_lock_o = lock_q;
  assign quad_enable_o = quad_q;
  assign drive_strength_o = drv_q;
  assign dummy_cycle_sel_o = dummy_q;
  assign hold_reset_sel_o = hrst_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_prog_hit;
    op_en_i && !is_chip && kind_ok && !pif.none && (op_addr_i >= pif.lo) &&
      (op_addr_i <= pif.hi);
  endsequence

  sequence s_rejected;
    op_done_o && op_reject_o && !op_allow_o;
  endsequence

  a_low_byte_read: assert property (
    rd_en_i && (rd_sel_i == faps_pkg::SEL_LOW) |=>
      rd_valid_o && (rd_data_o[1:0] == $past({wr_latch_i, busy_i})) &&
      (rd_data_o[6:2] == $past(bp_q)))
    else $error("low status byte read mismatch");

  a_mid_susp_read: assert property (
    rd_en_i && (rd_sel_i == faps_pkg::SEL_MID) |=>
      (rd_data_o[7] == $past(erase_susp_i)) && (rd_data_o[2] == $past(prog_susp_i)))
    else $error("suspend flags not shown in mid byte");

  a_lock_stays_set: assert property (
    ($past(lock_q) & ~lock_q) == 3'h0)
    else $error("security lock bit returned to zero");

  a_high_resv_zero: assert property (
    rd_en_i && (rd_sel_i == faps_pkg::SEL_HIGH) |=> (rd_data_o[4:1] == 4'h0))
    else $error("reserved high bits read nonzero");

  a_drive_field_write: assert property (
    wr_high |=> (drive_strength_o ==
      $past(wr_data_i[faps_pkg::HIGH_DRV_MSB:faps_pkg::HIGH_DRV_LSB])) ##1
      ($stable(drive_strength_o) || $past(wr_high)))
    else $error("drive strength field not stored");

  a_cmp_all_none: assert property (
    (pif.bp[2:0] == 3'h0) |-> (pif.compl ? (!pif.none && pif.lo == 24'h000000 &&
      pif.hi == 24'hffffff) : pif.none))
    else $error("code 000 range wrong");

  a_code_seven_range: assert property (
    (pif.bp[2:0] == 3'h7) |-> (pif.compl ? pif.none : (!pif.none && pif.lo == 24'h000000 &&
      pif.hi == 24'hffffff)))
    else $error("code 111 range wrong");

  a_cmp_low_half: assert property (
    pif.compl && (pif.bp == 5'h06) |-> (pif.lo == 24'h000000) && (pif.hi == 24'h7fffff))
    else $error("complement lower half wrong");

  a_cmp_upper_start: assert property (
    pif.compl && (pif.bp == 5'h09) |-> (pif.lo == 24'h040000) && (pif.hi == 24'hffffff))
    else $error("complement upper 63/64 wrong");

  a_cmp_top_small: assert property (
    pif.compl && (pif.bp[4:3] == 2'h2) && (pif.bp[2:0] inside {3'h4, 3'h5, 3'h6}) |->
      (pif.hi == 24'hff7fff) && (pif.lo == 24'h000000))
    else $error("complement top 32 KB exclusion wrong");

  a_cmp_bot_small: assert property (
    pif.compl && (pif.bp == 5'h19) |-> (pif.lo == 24'h001000) && (pif.hi == 24'hffffff))
    else $error("complement bottom 4 KB exclusion wrong");

  a_bottom_16k: assert property (
    !pif.compl && (pif.bp == 5'h1b) |-> (pif.lo == 24'h000000) && (pif.hi == 24'h003fff))
    else $error("bottom 16 KB range wrong");

  a_top_64th: assert property (
    !pif.compl && (pif.bp == 5'h01) |-> (pif.lo == 24'hfc0000) && (pif.hi == 24'hffffff))
    else $error("top 1/64 range wrong");

  a_prog_rejected: assert property (
    s_prog_hit |=> s_rejected)
    else $error("write into protected region allowed");

  a_chip_erase_gate: assert property (
    op_en_i && is_chip |=> (op_allow_o == $past(compl_q ? (bp_q[2:0] == 3'h7) :
      (bp_q[2:0] == 3'h0))))
    else $error("chip erase gating wrong");

  a_range_follows: assert property (
    wr_low |=> (pif.bp == $past(wr_bp)) ##1 ((prot_lo_o == $past(pif.lo)) &&
      (prot_hi_o == $past(pif.hi)) && (prot_none_o == $past(pif.none))))
    else $error("protected range lags status write");

endmodule // faps_top

// [test/faps_host.sv]
`timescale 1ns/10ps
// ==========================================================
// host controller issuing status read and write commands
module faps_host (
  // clock
  input wire logic clk_i,
  // status commands
  output logic wr_en_o,
  output logic [1:0] wr_sel_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  output logic [1:0] rd_sel_o,
  // read answer
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i
);
  initial
  begin
    wr_en_o = 1'b0;
    wr_sel_o = 2'h0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
    rd_sel_o = 2'h0;
  end

  task automatic write_byte(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_sel_o <= sel;
    wr_data_o <= (sel == 2'h2) ? (d & 8'he1) : d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    // released lines show garbage, never the last value
    wr_sel_o <= ~sel;
    wr_data_o <= ~d;
  endtask

  task automatic read_byte(input logic [1:0] sel, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    rd_sel_o <= sel;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    rd_sel_o <= ~sel;
    #1;
    v = rd_valid_i;
    d = rd_data_i;
  endtask
endmodule // faps_host

// [test/flash_array_protect_and_status_tb.sv]
`timescale 1ns/10ps
module flash_array_protect_and_status_tb;
  logic clk_i, rst_n_i, busy_i, wr_latch_i, erase_susp_i, prog_susp_i, op_en_i;
  logic [2:0] op_kind_i;
  logic [23:0] op_addr_i;
  logic wr_en, rd_en, rd_valid, op_done, op_allow, op_reject, prot_none, quad_o, dummy_o, hr_o;
  logic [1:0] wr_sel, rd_sel, sp_o, drv_o;
  logic [7:0] wr_data, rd_data;
  logic [23:0] prot_lo, prot_hi;
  logic [2:0] lock_o;
  int n_errors, total_checks, cycles;
  // reference state of the stored bits
  int bp, compl, lck, sp0, sp1, quad, hr, drv, dummy;
  logic [23:0] masks [4] = '{24'h0000ff, 24'h000fff, 24'h007fff, 24'h00ffff};

  always #2 clk_i = ~clk_i;

  faps_host host (.clk_i(clk_i), .wr_en_o(wr_en), .wr_sel_o(wr_sel), .wr_data_o(wr_data),
    .rd_en_o(rd_en), .rd_sel_o(rd_sel), .rd_valid_i(rd_valid), .rd_data_i(rd_data));

  faps_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_sel_i(wr_sel),
    .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_sel_i(rd_sel), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .busy_i(busy_i), .wr_latch_i(wr_latch_i), .erase_susp_i(erase_susp_i),
    .prog_susp_i(prog_susp_i), .op_en_i(op_en_i), .op_kind_i(op_kind_i),
    .op_addr_i(op_addr_i), .op_done_o(op_done), .op_allow_o(op_allow),
    .op_reject_o(op_reject), .prot_none_o(prot_none), .prot_lo_o(prot_lo),
    .prot_hi_o(prot_hi), .status_protect_o(sp_o), .security_lock_o(lock_o),
    .quad_enable_o(quad_o), .drive_strength_o(drv_o), .dummy_cycle_sel_o(dummy_o),
    .hold_reset_sel_o(hr_o));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input int sel, input logic [7:0] d);
    host.write_byte(2'(sel), d);
    if (sel == 0)
    begin
      sp0 = d[7];
      bp = d[6:2];
    end
    if (sel == 1)
    begin
      compl = d[6];
      lck = lck | d[5:3];
      quad = d[1];
      sp1 = d[0];
    end
    if (sel == 2)
    begin
      hr = d[7];
      drv = d[6:5];
      dummy = d[0];
    end
  endtask

  // range as the tables give it; the complement swaps which end is kept
  task automatic calc(output logic n, output logic [23:0] lo, output logic [23:0] hi);
    int c;
    int s;
    c = bp & 7;
    s = bp[4] ? (1 << (11 + ((c > 4) ? 4 : c))) : (1 << (17 + c));
    n = (c == 0 && compl == 0) || (c == 7 && compl == 1);
    lo = 24'h000000;
    hi = n ? 24'h000000 : 24'hffffff;
    if (c != 0 && c != 7)
    begin
      if (bp[3] == compl[0])
        lo = 24'(compl ? s : 32'h1000000 - s);
      else
        hi = 24'(compl ? 32'h1000000 - s - 1 : s - 1);
    end
  endtask

  task automatic check_state;
    logic n;
    logic [23:0] lo, hi;
    @(posedge clk_i);
    #1;
    calc(n, lo, hi);
    check({prot_none, prot_lo, prot_hi}, {n, lo, hi});
    check({sp_o, lock_o, quad_o, drv_o, dummy_o, hr_o},
      {sp1[0], sp0[0], lck[2:0], quad[0], drv[1:0], dummy[0], hr[0]});
  endtask

  task automatic read_all;
    logic [7:0] d, e, m;
    logic v;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_i);
      {busy_i, wr_latch_i, erase_susp_i, prog_susp_i} <= 4'($urandom);
      host.read_byte(2'(s), d, v);
      e = (s == 0) ? {sp0[0], bp[4:0], wr_latch_i, busy_i} :
          (s == 1) ? {erase_susp_i, compl[0], lck[2:0], prog_susp_i, quad[0], sp1[0]} :
          (s == 2) ? {hr[0], drv[1:0], 4'h0, dummy[0]} : 8'h00;
      m = (s == 2) ? 8'he1 : 8'hff;
      check(v, 1'b1);
      check(d & m, e & m);
    end
  endtask

  task automatic do_op(input int k, input logic [23:0] a);
    logic n, ok;
    logic [23:0] lo, hi, m;
    int c;
    calc(n, lo, hi);
    c = bp & 7;
    m = masks[k & 3];
    if (k == 4)
      ok = (c == 0 && compl == 0) || (c == 7 && compl == 1);
    else
      ok = (k < 4) && (n || !(((a & ~m) <= hi) && ((a | m) >= lo)));
    @(posedge clk_i);
    op_en_i <= 1'b1;
    op_kind_i <= 3'(k);
    op_addr_i <= a;
    @(posedge clk_i);
    op_en_i <= 1'b0;
    op_addr_i <= ~a;
    #1;
    check({op_done, op_allow, op_reject}, {1'b1, ok, !ok});
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    logic n;
    logic [23:0] lo, hi;
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    {busy_i, wr_latch_i, erase_susp_i, prog_susp_i, op_en_i} = 5'h00;
    op_kind_i = 3'h0;
    op_addr_i = 24'h000000;
    {bp, compl, lck, sp0, sp1, quad, hr, dummy} = 256'h0;
    drv = 1;
    void'($urandom(88741));
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    read_all();
    // a lock bit once set survives a write of zero
    wr(1, 8'h10);
    wr(1, 8'h00);
    check_state();
    read_all();
    for (int k = 0; k < 64; k++)
    begin
      wr(0, {1'($urandom), 5'(k), 2'h3});
      wr(1, {1'b1, 1'(k >> 5), 3'h0, 1'b1, 2'($urandom)});
      check_state();
      calc(n, lo, hi);
      do_op(4, 24'($urandom));
      do_op($urandom_range(3, 0), lo);
      do_op($urandom_range(3, 0), hi);
      do_op(0, lo - 24'h000001);
      do_op(0, hi + 24'h000001);
    end
    repeat (200)
    begin
      wr($urandom_range(3, 0), 8'($urandom));
      check_state();
      read_all();
      do_op($urandom_range(7, 0), 24'($urandom));
    end
    wrap_up();
  end
endmodule // flash_array_protect_and_status_tb
